// file: pit_counter.sv
// Purpose: Sixteen-bit down counter with period register
// Assumes: Tick is a one-cycle pulse
// Notes:   Period register is deliberately not reset
`timescale 1ns/100ps
module pit_counter
    import pit_pkg::*;
#(
    parameter int CNT_W = PIT_CNT_W
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire pit_load_type     load,
    input  wire logic             tick,
    input  wire logic             reload_mode,
    output logic [CNT_W-1:0]      count,
    output logic                  zero_event
);
    typedef enum logic [0:0] {
        PIT_IDLE   = 1'b0,
        PIT_ACTIVE = 1'b1
    } pit_state_type;

    pit_state_type    state_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] period_reg;
    logic             hit;

    assign count      = count_reg;
    assign hit        = (state_reg == PIT_ACTIVE) && tick && (count_reg == CNT_W'(1));
    assign zero_event = hit;

    always_ff @(posedge aclk) begin
        if (load.load) begin
            period_reg <= load.value[CNT_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= CNT_W'(PIT_CNT_RESET);
            state_reg <= PIT_IDLE;
        end else if (load.load) begin
            count_reg <= load.value[CNT_W-1:0];
            state_reg <= (load.value == PIT_CNT_RESET) ? PIT_IDLE : PIT_ACTIVE;
        end else begin
            unique case (state_reg)
                PIT_IDLE: begin
                    state_reg <= PIT_IDLE;
                end
                PIT_ACTIVE: begin
                    if (hit && reload_mode && period_reg != '0) begin
                        count_reg <= period_reg;
                    end else if (hit) begin
                        count_reg <= '0;
                        state_reg <= PIT_IDLE;
                    end else if (tick) begin
                        count_reg <= count_reg - CNT_W'(1);
                    end
                end
            endcase
        end
    end
endmodule // pit_counter

// file: pit_pkg.sv
// Purpose: Shared constants and types for the prescaled interval timer
// Assumes: AXI4-Lite register access, 32-bit data, single clock domain
// Notes:   Register offsets are byte addresses
//
// How it works
// - Sixteen-bit down counter, one step per tick
// - Zero reached raises interrupt when enable and mask set
// - No reload: stop at zero until written
// - Count write loads counter and period together
// - Reload: zero reloads period, repeats forever
// - Stop, restart, reload anytime; live count read
// - Stop/start error at most one tick
// - Reset clears control, count and counter
// - Reset alone never raises interrupt
// - Period register not cleared by reset
// - Count enable gates ticks, else hold
// - Divider select picks one of sixteen rates
// - Control disable bit stops timer and prescaler
// - Power control bit 4 also stops timer
package pit_pkg;
    localparam int           PIT_CNT_W        = 16;
    localparam int           PIT_PRE_W        = 17;
    localparam logic [7:0]   PIT_OFS_CTRL     = 8'h00;
    localparam logic [7:0]   PIT_OFS_COUNT    = 8'h04;
    localparam logic [7:0]   PIT_OFS_POWER    = 8'h08;
    localparam logic [7:0]   PIT_OFS_IRQ_EN   = 8'h0c;
    localparam logic [7:0]   PIT_OFS_STATUS   = 8'h10;
    localparam logic [7:0]   PIT_OFS_MASK     = 8'h14;
    localparam logic [7:0]   PIT_OFS_VECTOR   = 8'h18;
    // Control layout: [3:0] divider select, [4] reload, [5] count enable, [6] disable
    localparam int           PIT_CTL_SEL_LO   = 0;
    localparam int           PIT_CTL_RELOAD   = 4;
    localparam int           PIT_CTL_ENABLE   = 5;
    localparam int           PIT_CTL_DISABLE  = 6;
    localparam int           PIT_PWR_TIMEROFF = 4;
    localparam int           PIT_IEN_TIMER    = 8;
    localparam logic [6:0]   PIT_CTL_RESET    = 7'h00;
    localparam logic [15:0]  PIT_CNT_RESET    = 16'h0000;
    localparam logic [15:0]  PIT_VECTOR_ADDR  = 16'h0008;
    localparam logic [1:0]   PIT_RESP_OKAY    = 2'b00;
    localparam logic [1:0]   PIT_RESP_SLVERR  = 2'b10;

    typedef struct packed {
        logic        disable_bit;
        logic        count_enable_bit;
        logic        reload_bit;
        logic [3:0]  clock_divider_select;
    } pit_ctrl_type;

    typedef struct packed {
        logic        load;
        logic [15:0] value;
    } pit_load_type;
endpackage

// file: pit_prescaler.sv
// Purpose: Binary prescaler producing a one-cycle tick
// Assumes: Single clock, synchronous active-low reset
// Notes:   Held cleared while stopped, so restart costs at most one period
`timescale 1ns/100ps
module pit_prescaler
    import pit_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        run,
    input  wire logic [3:0]  select,
    output logic             tick
);
    logic [PIT_PRE_W-1:0] div_reg;
    logic [PIT_PRE_W-1:0] terminal;

    // Code k ends a period every 2^(k+1) clocks
    assign terminal = PIT_PRE_W'((PIT_PRE_W'(2) << select) - PIT_PRE_W'(1));
    assign tick     = run && (div_reg >= terminal);

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            div_reg <= '0;
        end else if (tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + PIT_PRE_W'(1);
        end
    end
endmodule // pit_prescaler

// file: pit_timer.sv
// Purpose: Prescaled interval timer with AXI4-Lite registers and interrupt
// Assumes: One clock, synchronous active-low reset, one access each way at a time
// Notes:   Live count readable at any time
`timescale 1ns/100ps
module pit_timer
    import pit_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic [2:0]   s_axi_awprot,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic [2:0]   s_axi_arprot,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic              irq,
    output logic              vector_valid,
    output logic [15:0]       vector_addr
);
    function automatic logic mapped(input logic [7:0] a);
        return a == PIT_OFS_CTRL || a == PIT_OFS_COUNT || a == PIT_OFS_POWER ||
               a == PIT_OFS_IRQ_EN || a == PIT_OFS_STATUS || a == PIT_OFS_MASK ||
               a == PIT_OFS_VECTOR;
    endfunction

    pit_ctrl_type    ctrl_reg;
    logic            power_off_reg;
    logic            irq_en_reg;
    logic            status_reg;
    logic            mask_reg;
    logic            vector_valid_reg;
    logic [7:0]      awaddr_reg;
    logic [31:0]     wdata_reg;
    logic [3:0]      wstrb_reg;
    logic            aw_have_reg;
    logic            w_have_reg;
    logic            bvalid_reg;
    logic [1:0]      bresp_reg;
    logic            rvalid_reg;
    logic [31:0]     rdata_reg;
    logic [1:0]      rresp_reg;
    logic            wr_fire;
    logic            rd_fire;
    logic            run;
    logic            tick;
    logic            zero_event;
    logic            timer_event;
    logic            status_clear;
    logic [15:0]     count;
    pit_load_type    load;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready  = !w_have_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign wr_fire       = aw_have_reg && w_have_reg && !bvalid_reg;
    assign rd_fire       = s_axi_arvalid && !rvalid_reg;

    // Either shutdown path stops the prescaler and so the counter
    assign run = ctrl_reg.count_enable_bit && !ctrl_reg.disable_bit
                 && !power_off_reg;

    assign load.load  = wr_fire && awaddr_reg == PIT_OFS_COUNT && (&wstrb_reg[1:0]);
    assign load.value = wdata_reg[15:0];

    // Counter runs regardless of enable; only the raised interrupt is gated
    assign timer_event  = zero_event && irq_en_reg;
    assign status_clear = rd_fire && s_axi_araddr == PIT_OFS_STATUS;
    assign irq          = status_reg && mask_reg;
    assign vector_valid = vector_valid_reg;
    assign vector_addr  = PIT_VECTOR_ADDR;

    pit_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (run),
        .select  (ctrl_reg.clock_divider_select),
        .tick    (tick)
    );

    pit_counter #(.CNT_W(PIT_CNT_W)) u_counter (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .load        (load),
        .tick        (tick),
        .reload_mode (ctrl_reg.reload_bit),
        .count       (count),
        .zero_event  (zero_event)
    );

    // Write channel capture, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= PIT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(awaddr_reg) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Control, power, interrupt enable and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg      <= PIT_CTL_RESET;
            power_off_reg <= 1'b0;
            irq_en_reg    <= 1'b0;
            mask_reg      <= 1'b0;
        end else if (wr_fire && wstrb_reg[0]) begin
            unique case (awaddr_reg)
                PIT_OFS_CTRL:   ctrl_reg      <= wdata_reg[PIT_CTL_DISABLE:PIT_CTL_SEL_LO];
                PIT_OFS_POWER:  power_off_reg <= wdata_reg[PIT_PWR_TIMEROFF];
                PIT_OFS_MASK:   mask_reg      <= wdata_reg[0];
                default: ;
            endcase
            if (awaddr_reg == PIT_OFS_IRQ_EN && wstrb_reg[1]) begin
                irq_en_reg <= wdata_reg[PIT_IEN_TIMER];
            end
        end else if (wr_fire && awaddr_reg == PIT_OFS_IRQ_EN && wstrb_reg[1]) begin
            irq_en_reg <= wdata_reg[PIT_IEN_TIMER];
        end
    end

    // Sticky status; a new event beats the read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg       <= 1'b0;
            vector_valid_reg <= 1'b0;
        end else begin
            vector_valid_reg <= timer_event;
            if (timer_event) begin
                status_reg <= 1'b1;
            end else if (status_clear) begin
                status_reg <= 1'b0;
            end
        end
    end

    // Read channel, count sampled live at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= PIT_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= mapped(s_axi_araddr) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
            unique case (s_axi_araddr)
                PIT_OFS_CTRL:   rdata_reg <= 32'(ctrl_reg);
                PIT_OFS_COUNT:  rdata_reg <= 32'(count);
                PIT_OFS_POWER:  rdata_reg <= 32'(power_off_reg) << PIT_PWR_TIMEROFF;
                PIT_OFS_IRQ_EN: rdata_reg <= 32'(irq_en_reg) << PIT_IEN_TIMER;
                PIT_OFS_STATUS: rdata_reg <= 32'(status_reg);
                PIT_OFS_MASK:   rdata_reg <= 32'(mask_reg);
                PIT_OFS_VECTOR: rdata_reg <= 32'(PIT_VECTOR_ADDR);
                default:        rdata_reg <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule // pit_timer

// file: pit_timer_monitor.sv
// Purpose: Bus handshake and interrupt checks for the interval timer
// Assumes: Sees only top-level ports, one clock domain
// Notes:   Count timing is judged by the bench, not here
`timescale 1ns/100ps
module pit_timer_monitor
    import pit_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq,
    input wire logic        vector_valid,
    input wire logic [15:0] vector_addr
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both halves of a write taken at one edge
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_vec_addr: assert property (vector_valid |-> vector_addr == PIT_VECTOR_ADDR)
        else $error("vector address wrong");
    a_vec_pulse: assert property (vector_valid |=> !vector_valid)
        else $error("vector pulse too long");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !vector_valid)
        else $error("interrupt out of reset");
    a_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule // pit_timer_monitor

bind pit_timer pit_timer_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .vector_valid(vector_valid), .vector_addr(vector_addr));

// file: tb_top.sv
// Purpose: Self-checking bench for the prescaled interval timer
// Assumes: Bench is the bus master, checker bound separately
// Notes:   Tick timing allows one tick of slack for stop and start
`timescale 1ns/100ps
module tb_top
    import pit_pkg::*;
;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [1:0]  resp;
    wire         awrdy, wrdy, bvalid, arrdy, rvalid, irq, vv;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] vaddr;
    int          fails = 0, check_count = 0, cyc = 0, t, a;
    int          m[8] = '{0, 0, 0, 0, 0, 0, 8, 0};
    int          fm[8] = '{'h7f, 'hffff, 'h10, 'h100, 0, 1, 0, 0};
    int          ra[4] = '{0, 8, 'hc, 'h14};
    int          sa[3] = '{0, 0, 8};
    int          sd[3] = '{0, 'h60, 'h10};

    pit_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .vector_valid(vv), .vector_addr(vaddr));

    initial begin
        forever #4 aclk = ~aclk;
    end

    // Hang guard, far above the thousand or so cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_rng(input string n, input int lo, input int hi, input logic signed [31:0] g);
        check_count++;
        if ($isunknown(g) || g < lo || g > hi) begin
            fails++;
            $display("MISMATCH %s exp %0d..%0d got %0d", n, lo, hi, g);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        // Late ready at random keeps the held-answer checks live
        bready <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (awv && awrdy) awv <= 0;
            if (wv && wrdy) wv <= 0;
            if (bvalid && !bready) bready <= 1;
        end while (!(bvalid && bready));
        bready <= 0;
        chk("bresp", (ad == 8'h1c) ? PIT_RESP_SLVERR : PIT_RESP_OKAY, bresp);
        if (ad != 8'h1c) m[ad[4:2]] = d & fm[ad[4:2]];
    endtask

    task automatic rdr(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad;
        arv <= 1;
        rready <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (arv && arrdy) arv <= 0;
            if (rvalid && !rready) rready <= 1;
        end while (!(rvalid && rready));
        rready <= 0;
        rd = rdata;
        resp = rresp;
    endtask

    // Cycles until a vector pulse; equals lim when none came
    task automatic wait_vec(input int lim);
        t = 0;
        do begin
            @(posedge aclk);
            t++;
        end while (!vv && t < lim);
    endtask

    task automatic results();
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        void'($urandom(39));
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 7; i++) begin
            rdr(i * 4);
            chk("reset reg", m[i], rd);
            chk("rresp", PIT_RESP_OKAY, resp);
        end
        chk("irq", 0, irq);
        wr(8'h1c, 32'hffffffff);
        rdr(8'h1c);
        chk("rresp", PIT_RESP_SLVERR, resp);
        chk("rdata", 0, rd);
        for (int i = 0; i < 8; i++) begin
            a = ra[i % 4];
            wr(a, $urandom);
            rdr(a);
            chk("field", m[a / 4], rd);
        end
        wr(0, 0);
        wr(8, 0);
        wr('hc, 'h100);
        wr('h14, 1);
        // One-shot at every low divider, random count
        for (int k = 0; k < 4; k++) begin
            a = 1 + $urandom % 6;
            wr(4, a);
            wr(0, 'h20 | k);
            wait_vec(a * (4 << k) + 20);
            chk_rng("period", (a - 1) * (2 << k), (a + 1) * (2 << k) + 4, t);
            chk("vector", PIT_VECTOR_ADDR, vaddr);
            rdr(4);
            chk("count", 0, rd);
            chk("irq", 1, irq);
            rdr('h10);
            chk("status", 1, rd);
            rdr('h10);
            chk("status", 0, rd);
            chk("irq", 0, irq);
            wait_vec(a * (4 << k));
            chk("rearm", a * (4 << k), t);
            wr(0, 0);
        end
        wr(4, 3);
        wr(0, 'h30);
        wait_vec(40);
        for (int i = 0; i < 2; i++) begin
            wait_vec(40);
            chk_rng("reload", 6, 6, t);
        end
        wr(4, 'h800);
        wr(0, 'h20);
        rdr(4);
        a = rd;
        repeat (20) @(posedge aclk);
        rdr(4);
        chk_rng("live", 1, 30, a - rd);
        // Each of the three ways to stop must freeze the count
        for (int i = 0; i < 3; i++) begin
            wr(sa[i], sd[i]);
            rdr(4);
            a = rd;
            repeat (20) @(posedge aclk);
            rdr(4);
            chk("hold", a, rd);
            wr(8, 0);
            wr(0, 'h20);
        end
        wr(0, 0);
        wr('hc, 0);
        // Reload events above left the sticky bit set
        rdr('h10);
        chk("status", 1, rd);
        wr(4, 2);
        wr(0, 'h20);
        wait_vec(30);
        chk("gated", 30, t);
        rdr('h10);
        chk("status", 0, rd);
        wr(0, 0);
        wr('hc, 'h100);
        wr('h14, 0);
        wr(4, 2);
        wr(0, 'h20);
        wait_vec(30);
        chk_rng("masked", 1, 29, t);
        chk("irq", 0, irq);
        rdr('h10);
        chk("status", 1, rd);
        wr(4, 0);
        wait_vec(30);
        chk("zero", 30, t);
        wr('h14, 1);
        wr(4, 3);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        m = '{0, 0, 0, 0, 0, 0, 8, 0};
        wait_vec(30);
        chk("reset vec", 30, t);
        chk("irq", 0, irq);
        rdr(0);
        chk("ctrl", 0, rd);
        rdr(4);
        chk("count", 0, rd);
        results();
    end
endmodule // tb_top
